// [core/acc_adc_ctrl.sv]
// converter control block with register file on an AXI4-Lite slave
`timescale 1ns/1ps
module acc_adc_ctrl (
    input wire logic aclk,                              // instruction clock
    input wire logic aresetn,                           // synchronous reset, active low
    input wire logic [acc_pkg::ACC_AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid,                     // write address valid
    output logic s_axi_awready,                         // write address ready
    input wire logic [acc_pkg::ACC_DW-1:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb,                 // write byte enables
    input wire logic s_axi_wvalid,                      // write data valid
    output logic s_axi_wready,                          // write data ready
    output logic [1:0] s_axi_bresp,                     // write response
    output logic s_axi_bvalid,                          // write response valid
    input wire logic s_axi_bready,                      // write response ready
    input wire logic [acc_pkg::ACC_AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid,                     // read address valid
    output logic s_axi_arready,                         // read address ready
    output logic [acc_pkg::ACC_DW-1:0] s_axi_rdata,     // read data
    output logic [1:0] s_axi_rresp,                     // read response
    output logic s_axi_rvalid,                          // read data valid
    input wire logic s_axi_rready,                      // read data ready
    input wire logic [acc_pkg::ACC_RES_W-1:0] sample_code, // code from analog front end
    output logic converter_power,                       // powers the analog converter
    output logic [acc_pkg::ACC_NCH-1:0] analog_select,  // one-hot input switch per pin
    output logic [acc_pkg::ACC_NCH-1:0] digital_isolate, // isolates digital buffer per pin
    output logic conv_busy                              // conversion running
);
    import acc_pkg::*;

    // bus state
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_held_q, w_held_q;
    logic [ACC_AW-1:0] wr_addr_q;
    logic [ACC_DW-1:0] wr_data_q;
    logic wr_lane0_q;
    logic [1:0] bresp_q, rresp_q;
    logic [ACC_DW-1:0] rdata_q;
    // registers
    logic [ACC_PCFG_HI:0] pin_cfg_q;
    logic en_q, start_q, done_q, gce_q;
    logic [ACC_CHS_HI:0] chs_q;
    logic [1:0] cks_q;
    logic [1:0] conv_cks_q;
    logic [ACC_RES_W-1:0] result_q;
    logic busy_q;
    logic [ACC_NCH-1:0] sel_q;
    // combinational
    logic wr_go, wr_hit, wr_pin, wr_mode, wr_rlo;
    logic start_now, cycle_done;
    logic [ACC_DW-1:0] rd_word;
    logic rd_hit;

    // ---------------- write channel ----------------
    assign wr_go = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            aw_held_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b1;
            wr_addr_q <= s_axi_awaddr;
        end else if (bvalid_q && s_axi_bready) begin
            awready_q <= 1'b1;
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            w_held_q <= 1'b0;
            wr_data_q <= '0;
            wr_lane0_q <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_held_q <= 1'b1;
            wr_data_q <= s_axi_wdata;
            wr_lane0_q <= s_axi_wstrb[0];
        end else if (bvalid_q && s_axi_bready) begin
            wready_q <= 1'b1;
            w_held_q <= 1'b0;
        end
    end

    always_comb begin
        wr_hit = (wr_addr_q == ACC_ADDR_PIN_CFG) || (wr_addr_q == ACC_ADDR_MODE) ||
                 (wr_addr_q == ACC_ADDR_RES_HI) || (wr_addr_q == ACC_ADDR_RES_LO);
        wr_pin = wr_go && wr_lane0_q && (wr_addr_q == ACC_ADDR_PIN_CFG);
        wr_mode = wr_go && wr_lane0_q && (wr_addr_q == ACC_ADDR_MODE);
        wr_rlo = wr_go && wr_lane0_q && (wr_addr_q == ACC_ADDR_RES_LO);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= ACC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ---------------- read channel ----------------
    always_comb begin
        rd_word = ACC_ZERO;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ACC_ADDR_PIN_CFG: rd_word[ACC_PCFG_HI:0] = pin_cfg_q;
            ACC_ADDR_MODE: begin
                rd_word[ACC_MODE_EN_BIT] = en_q;
                rd_word[ACC_MODE_START_BIT] = start_q;
                rd_word[ACC_MODE_DONE_BIT] = done_q;
                rd_word[ACC_MODE_GCE_BIT] = gce_q;
                rd_word[ACC_CHS_HI:ACC_CHS_LO] = chs_q;
            end
            ACC_ADDR_RES_HI: rd_word[ACC_RES_W-ACC_RHI_LSB-1:0] =
                result_q[ACC_RES_W-1:ACC_RHI_LSB];
            ACC_ADDR_RES_LO: begin
                rd_word[ACC_CKS_HI_BIT] = cks_q[1];
                rd_word[ACC_CKS_LO_BIT] = cks_q[0];
                rd_word[ACC_RLO_HI:0] = result_q[ACC_RLO_HI:0];
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= ACC_ZERO;
            rresp_q <= ACC_RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_cfg_q <= '0;
        end else if (wr_pin) begin
            pin_cfg_q <= wr_data_q[ACC_PCFG_HI:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= 1'b0;
            gce_q <= 1'b0;
            chs_q <= '0;
        end else if (wr_mode) begin
            en_q <= wr_data_q[ACC_MODE_EN_BIT];
            gce_q <= wr_data_q[ACC_MODE_GCE_BIT];
            chs_q <= wr_data_q[ACC_CHS_HI:ACC_CHS_LO];
        end
    end

    // only clock select bits are writable here; result bits ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cks_q <= ACC_CKS_DIV16;
        end else if (wr_rlo) begin
            cks_q <= {wr_data_q[ACC_CKS_HI_BIT], wr_data_q[ACC_CKS_LO_BIT]};
        end
    end

    // ---------------- conversion sequencing ----------------
    assign start_now = start_q && gce_q && en_q && !busy_q;
    assign conv_busy = busy_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            conv_cks_q <= ACC_CKS_DIV16;
        end else if (!en_q || cycle_done) begin
            busy_q <= 1'b0;
        end else if (start_now) begin
            busy_q <= 1'b1;
            conv_cks_q <= cks_q;
        end
    end

    // a software write of start wins over the automatic clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b0;
        end else if (wr_mode) begin
            start_q <= wr_data_q[ACC_MODE_START_BIT];
        end else if (cycle_done || (busy_q && !en_q)) begin
            start_q <= 1'b0;
        end
    end

    // completion sets done and wins over a software clear in the same cycle
    // software cannot raise done while a conversion runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
        end else if (cycle_done) begin
            done_q <= 1'b1;
        end else if (start_now) begin
            done_q <= 1'b0;
        end else if (wr_mode && !busy_q) begin
            done_q <= wr_data_q[ACC_MODE_DONE_BIT];
        end
    end

    // result has no reset; front end code is stored as straight binary
    always_ff @(posedge aclk) begin
        if (cycle_done) begin
            result_q <= sample_code;
        end
    end

    acc_conv_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(busy_q && en_q),
        .clk_sel(conv_cks_q),
        .done(cycle_done)
    );

    // ---------------- pin routing ----------------
    genvar gi;
    generate
        for (gi = 0; gi < ACC_NCH; gi++) begin : g_ch
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sel_q[gi] <= 1'b0;
                end else begin
                    sel_q[gi] <= en_q && gce_q && (chs_q == (ACC_CHS_HI+1)'(gi));
                end
            end
        end
    endgenerate

    assign analog_select = sel_q;
    assign digital_isolate = pin_cfg_q;
    assign converter_power = en_q;

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // checker helpers: cycles since the conversion began, its due length, result defined
    logic [ACC_CNT_W:0] len_q;
    logic [ACC_CNT_W:0] len_due;
    logic result_seen_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !busy_q) begin
            len_q <= '0;
        end else begin
            len_q <= len_q + 12'h001;
        end
    end

    always_comb begin
        case (conv_cks_q)
            ACC_CKS_DIV16: len_due = (ACC_CNT_W+1)'(ACC_CONV_CYCLES * ACC_DIV16);
            ACC_CKS_DIV8: len_due = (ACC_CNT_W+1)'(ACC_CONV_CYCLES * ACC_DIV8);
            ACC_CKS_DIV1: len_due = (ACC_CNT_W+1)'(ACC_CONV_CYCLES * ACC_DIV1);
            ACC_CKS_DIV2: len_due = (ACC_CNT_W+1)'(ACC_CONV_CYCLES * ACC_DIV2);
            default: len_due = (ACC_CNT_W+1)'(ACC_CONV_CYCLES * ACC_DIV16);
        endcase
    end

    // the result register holds no defined value before the first completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_seen_q <= 1'b0;
        end else if (cycle_done) begin
            result_seen_q <= 1'b1;
        end
    end

    a_start_needs_gce: assert property ($rose(busy_q) |-> $past(gce_q) && $past(start_q))
        else $error("conversion began without enable and start");
    a_done_low_busy: assert property (busy_q && !cycle_done |-> ##1 !done_q || !busy_q)
        else $error("done high during conversion");
    a_done_sets: assert property (cycle_done |=> done_q && !busy_q && (!start_q || $past(wr_mode)))
        else $error("completion did not set done and clear start");
    a_power_follows: assert property (wr_mode |=> converter_power == $past(wr_data_q[ACC_MODE_EN_BIT]))
        else $error("power does not follow enable bit");
    a_sel_onehot: assert property ($onehot0(analog_select))
        else $error("more than one input connected");
    a_sel_gce: assert property (!gce_q |=> analog_select == '0)
        else $error("input connected while global enable low");
    a_sel_chan: assert property (en_q && gce_q && chs_q == 3'h4 |=> analog_select[4])
        else $error("wrong input routed");
    a_conv_length: assert property (busy_q |-> cycle_done == (len_q == len_due))
        else $error("conversion length differs from sixty-four conversion clocks");
    a_result_hold: assert property (result_seen_q && !cycle_done |=> $stable(result_q))
        else $error("result changed without completion");
    a_abort: assert property (busy_q && !en_q |=> !busy_q)
        else $error("conversion not aborted");
    a_clear_done: assert property (start_now |=> !done_q)
        else $error("done not cleared at start");

    c_conv_done: cover property (cycle_done);
    c_abort: cover property (busy_q && !en_q);
    c_pending_start: cover property (start_q && en_q && !gce_q);
    c_write_read: cover property (s_axi_bvalid ##[1:20] s_axi_rvalid);
endmodule

// [core/acc_conv_timer.sv]
// conversion length timer: counts conversion clock cycles in instruction clocks
`timescale 1ns/1ps
module acc_conv_timer (
    input wire logic aclk,                  // instruction clock
    input wire logic aresetn,               // synchronous reset, active low
    input wire logic run,                   // conversion in progress
    input wire logic [1:0] clk_sel,         // conversion clock code
    output logic done                       // one-cycle pulse at end of conversion
);
    import acc_pkg::*;

    logic [ACC_CNT_W-1:0] div;
    logic [ACC_CNT_W-1:0] last;
    logic [ACC_CNT_W-1:0] cnt_q;
    logic done_q;

    always_comb begin
        case (clk_sel)
            ACC_CKS_DIV16: div = ACC_DIV16;
            ACC_CKS_DIV8: div = ACC_DIV8;
            ACC_CKS_DIV1: div = ACC_DIV1;
            ACC_CKS_DIV2: div = ACC_DIV2;
            default: div = ACC_DIV16;
        endcase
        last = ACC_CNT_W'(ACC_CONV_CYCLES * div - 11'h001);
    end

    // dropping run restarts the count, which aborts a conversion
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else if (cnt_q == last) begin
            cnt_q <= '0;
            done_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 11'h001;
            done_q <= 1'b0;
        end
    end

    assign done = done_q;
endmodule

// [core/acc_pkg.sv]
// constants and register map for the converter control block
package acc_pkg;
    localparam int ACC_AW = 12;
    localparam int ACC_DW = 32;
    localparam int ACC_RES_W = 12;
    localparam int ACC_NCH = 5;
    localparam int ACC_CNT_W = 11;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] ACC_IDX_PIN_CFG = 8'hAE;
    localparam logic [7:0] ACC_IDX_MODE = 8'hB1;
    localparam logic [7:0] ACC_IDX_RES_HI = 8'hB2;
    localparam logic [7:0] ACC_IDX_RES_LO = 8'hB3;
    localparam logic [ACC_AW-1:0] ACC_ADDR_PIN_CFG = {2'h0, ACC_IDX_PIN_CFG, 2'h0};
    localparam logic [ACC_AW-1:0] ACC_ADDR_MODE = {2'h0, ACC_IDX_MODE, 2'h0};
    localparam logic [ACC_AW-1:0] ACC_ADDR_RES_HI = {2'h0, ACC_IDX_RES_HI, 2'h0};
    localparam logic [ACC_AW-1:0] ACC_ADDR_RES_LO = {2'h0, ACC_IDX_RES_LO, 2'h0};

    // converter_mode fields
    localparam int ACC_MODE_EN_BIT = 7;
    localparam int ACC_MODE_START_BIT = 6;
    localparam int ACC_MODE_DONE_BIT = 5;
    localparam int ACC_MODE_GCE_BIT = 4;
    localparam int ACC_CHS_HI = 2;
    localparam int ACC_CHS_LO = 0;
    // result_low_and_clock fields, result high/low split and pin configuration width
    localparam int ACC_CKS_HI_BIT = 6;
    localparam int ACC_CKS_LO_BIT = 4;
    localparam int ACC_RLO_HI = 3;
    localparam int ACC_RHI_LSB = 4;
    localparam int ACC_PCFG_HI = 4;

    // conversion clock select codes and their divisors
    localparam logic [1:0] ACC_CKS_DIV16 = 2'h0;
    localparam logic [1:0] ACC_CKS_DIV8 = 2'h1;
    localparam logic [1:0] ACC_CKS_DIV1 = 2'h2;
    localparam logic [1:0] ACC_CKS_DIV2 = 2'h3;
    localparam logic [ACC_CNT_W-1:0] ACC_DIV16 = 11'h010;
    localparam logic [ACC_CNT_W-1:0] ACC_DIV8 = 11'h008;
    localparam logic [ACC_CNT_W-1:0] ACC_DIV1 = 11'h001;
    localparam logic [ACC_CNT_W-1:0] ACC_DIV2 = 11'h002;

    // sixteen periods of the conversion clock divided by four
    localparam int ACC_CONV_PERIODS = 16;
    localparam int ACC_CONV_PRESCALE = 4;
    localparam logic [ACC_CNT_W-1:0] ACC_CONV_CYCLES =
        ACC_CNT_W'(ACC_CONV_PERIODS * ACC_CONV_PRESCALE);

    localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;
    localparam logic [ACC_DW-1:0] ACC_ZERO = 32'h0000_0000;
endpackage

// [verification/acc_adc_ctrl_tb.sv]
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module tb;
    import acc_pkg::*;
    logic aclk;
    logic aresetn;
    logic [ACC_AW-1:0] awaddr;
    logic awvalid;
    logic awready;
    logic [ACC_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [ACC_AW-1:0] araddr;
    logic arvalid;
    logic arready;
    logic [ACC_DW-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic [ACC_RES_W-1:0] sample_code;
    logic converter_power;
    logic [ACC_NCH-1:0] analog_select;
    logic [ACC_NCH-1:0] digital_isolate;
    logic conv_busy;
    int bad_count;
    int total_checks;
    logic [11:0] last_code;
    localparam int SETTLE_CYCLES = 12500; // 100 us of 8 ns cycles

    acc_adc_ctrl u_acc_adc_ctrl (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sample_code(sample_code), .converter_power(converter_power),
        .analog_select(analog_select), .digital_isolate(digital_isolate), .conv_busy(conv_busy)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // write address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] exp_resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, exp_resp});
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] mask,
                          input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(name, d & mask, exp);
        check("rresp", {30'h0, r}, {30'h0, ACC_RESP_OKAY});
    endtask

    task automatic t_reset_values();
        rd_chk("mode_rst", ACC_ADDR_MODE, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk("pincfg_rst", ACC_ADDR_PIN_CFG, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk("cks_rst", ACC_ADDR_RES_LO, 32'hFFFF_FFF0, 32'h0000_0000);
        check("busy_rst", {31'h0, conv_busy}, 32'h0);
        check("select_rst", {27'h0, analog_select}, 32'h0);
    endtask

    task automatic t_pin_config();
        wr(ACC_ADDR_PIN_CFG, 8'h15, ACC_RESP_OKAY);
        rd_chk("pincfg", ACC_ADDR_PIN_CFG, 32'hFFFF_FFFF, 32'h0000_0015);
        check("isolate", {27'h0, digital_isolate}, 32'h15);
        wr(ACC_ADDR_PIN_CFG, 8'hFF, ACC_RESP_OKAY);
        rd_chk("pincfg_all", ACC_ADDR_PIN_CFG, 32'hFFFF_FFFF, 32'h0000_001F);
        check("isolate_all", {27'h0, digital_isolate}, 32'h1F);
    endtask

    task automatic t_channels();
        for (int ch = 0; ch < 5; ch++) begin
            wr(ACC_ADDR_MODE, 8'h90 | 8'(ch), ACC_RESP_OKAY);
            repeat (2) @(posedge aclk);
            check("select", {27'h0, analog_select}, 32'h1 << ch);
            check("power", {31'h0, converter_power}, 32'h1);
        end
        wr(ACC_ADDR_MODE, 8'h84, ACC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("select_gce_off", {27'h0, analog_select}, 32'h0);
        wr(ACC_ADDR_MODE, 8'h12, ACC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("select_en_off", {27'h0, analog_select}, 32'h0);
        check("power_off", {31'h0, converter_power}, 32'h0);
    endtask

    task automatic t_convert(input logic [1:0] cks, input logic [11:0] code, input int div);
        int cnt;
        sample_code <= code;
        wr(ACC_ADDR_RES_LO, {1'b0, cks[1], 1'b0, cks[0], 4'h0}, ACC_RESP_OKAY);
        wr(ACC_ADDR_MODE, 8'hD0, ACC_RESP_OKAY);
        while (!conv_busy) @(posedge aclk);
        cnt = 0;
        while (conv_busy) begin
            cnt++;
            @(posedge aclk);
        end
        check("conv_len", 32'(cnt >= 64 * div && cnt <= 64 * div + 1), 32'h1);
        rd_chk("mode_done", ACC_ADDR_MODE, 32'hFFFF_FFFF, 32'h0000_00B0);
        rd_chk("res_hi", ACC_ADDR_RES_HI, 32'hFFFF_FFFF, {24'h0, code[11:4]});
        rd_chk("res_lo", ACC_ADDR_RES_LO, 32'hFFFF_FFFF,
               {24'h0, 1'b0, cks[1], 1'b0, cks[0], code[3:0]});
        last_code = code;
    endtask

    task automatic t_result_read_only();
        logic [31:0] hi;
        logic [31:0] lo;
        logic [1:0] r;
        wr(ACC_ADDR_RES_HI, ~last_code[11:4], ACC_RESP_OKAY);
        wr(ACC_ADDR_RES_LO, {4'h0, ~last_code[3:0]}, ACC_RESP_OKAY);
        rd_chk("ro_hi", ACC_ADDR_RES_HI, 32'hFFFF_FFFF, {24'h0, last_code[11:4]});
        rd_chk("ro_lo", ACC_ADDR_RES_LO, 32'hFFFF_FFFF, {28'h0, last_code[3:0]});
        rd(ACC_ADDR_RES_HI, hi, r);
        rd(ACC_ADDR_RES_LO, lo, r);
        check("res_10bit", {22'h0, hi[7:0], lo[3:2]}, {22'h0, last_code[11:2]});
    endtask

    // software duty: settle after enabling, pin 0 kept analog and the others digital
    task automatic t_settle();
        wr(ACC_ADDR_PIN_CFG, 8'h01, ACC_RESP_OKAY);
        check("isolate_pin0", {27'h0, digital_isolate}, 32'h01);
        wr(ACC_ADDR_MODE, 8'h90, ACC_RESP_OKAY);
        repeat (SETTLE_CYCLES) @(posedge aclk);
        check("power_settle", {31'h0, converter_power}, 32'h1);
    endtask

    task automatic t_gate_and_abort();
        wr(ACC_ADDR_MODE, 8'hC0, ACC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        check("no_start_gce0", {31'h0, conv_busy}, 32'h0);
        check("select_gce0", {27'h0, analog_select}, 32'h0);
        wr(ACC_ADDR_MODE, 8'hF0, ACC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("busy_started", {31'h0, conv_busy}, 32'h1);
        rd_chk("done_cleared", ACC_ADDR_MODE, 32'hFFFF_FFFF, 32'h0000_00D0);
        wr(ACC_ADDR_MODE, 8'h10, ACC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("busy_abort", {31'h0, conv_busy}, 32'h0);
        rd_chk("mode_abort", ACC_ADDR_MODE, 32'hFFFF_FFFF, 32'h0000_0010);
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h000, 8'h5A, ACC_RESP_SLVERR);
        rd(12'h000, d, r);
        check("unmapped_data", d, ACC_ZERO);
        check("unmapped_resp", {30'h0, r}, {30'h0, ACC_RESP_SLVERR});
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        bad_count++;
        conclude();
    end

    initial begin
        bad_count = 0;
        total_checks = 0;
        aresetn = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        sample_code = 12'h000;
        last_code = 12'h000;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
        t_pin_config();
        t_channels();
        t_settle();
        t_convert(2'h0, 12'h000, 16);
        t_convert(2'h1, 12'hFFF, 8);
        t_convert(2'h2, 12'hA5C, 1);
        t_convert(2'h3, 12'h3C1, 2);
        t_result_read_only();
        t_gate_and_abort();
        t_unmapped();
        conclude();
    end
endmodule
